// [design/sss_pkg.sv]
/*
  package of the synchronous serial slave: register offsets, field
  positions, reset values and the transmit state type.
  assumes an apb bus with 32-bit data and byte addresses.
*/
package sss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] SSS_OFS_RX_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] SSS_OFS_TX_STATUS_CONTROL = 12'h004;
  localparam logic [11:0] SSS_OFS_RECEIVE_DATA = 12'h008;
  localparam logic [11:0] SSS_OFS_TRANSMIT_BUFFER = 12'h00c;
  localparam logic [11:0] SSS_OFS_FLAGS_ENABLES = 12'h010;
  localparam logic [11:0] SSS_OFS_BAUD_CONTROL = 12'h014;

  ////////////////////////////////////////////////////////////////////////////
  // receive_status_control fields
  localparam int SSS_RSC_PORT_ENABLE = 7;
  localparam int SSS_RSC_NINE_BIT_RECEIVE = 6;
  localparam int SSS_RSC_SINGLE_RECEIVE = 5;
  localparam int SSS_RSC_CONT_RECEIVE = 4;
  localparam int SSS_RSC_OVERRUN_ERROR = 1;
  localparam int SSS_RSC_NINTH_BIT = 0;
  localparam logic [7:0] SSS_RSC_WRITE_MASK = 8'hf0;

  // transmit_status_control fields
  localparam int SSS_TSC_CLOCK_MASTER = 7;
  localparam int SSS_TSC_NINE_BIT_SEND = 6;
  localparam int SSS_TSC_SEND_ENABLE = 5;
  localparam int SSS_TSC_SYNC_MODE = 4;
  localparam int SSS_TSC_SHIFT_EMPTY = 1;
  localparam int SSS_TSC_NINTH_SEND_BIT = 0;
  localparam logic [7:0] SSS_TSC_WRITE_MASK = 8'hf1;

  // flags and enables fields
  localparam int SSS_FE_RX_COMPLETE = 0;
  localparam int SSS_FE_TX_EMPTY = 1;
  localparam int SSS_FE_RX_INT_EN = 4;
  localparam int SSS_FE_TX_INT_EN = 5;
  localparam int SSS_FE_PERIPH_INT_EN = 6;
  localparam int SSS_FE_GLOBAL_INT_EN = 7;
  localparam logic [7:0] SSS_FE_WRITE_MASK = 8'hf0;

  // baud_control fields
  localparam int SSS_BC_CLOCK_POLARITY = 4;
  localparam int SSS_BC_RX_IDLE = 6;
  localparam logic [7:0] SSS_BC_WRITE_MASK = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and fixed figures
  localparam logic [7:0] SSS_RESET_CONTROL = 8'h00;
  localparam logic [15:0] SSS_ISR_VECTOR = 16'h0004;
  localparam logic [3:0] SSS_LAST_BIT_8 = 4'h7;
  localparam logic [3:0] SSS_LAST_BIT_9 = 4'h8;

  typedef enum logic {SSS_TX_IDLE, SSS_TX_SHIFT} sss_tx_state_type;

endpackage

// [design/sss_top.sv]
/*
  synchronous serial slave: receives and sends 8- or 9-bit words clocked
  by an external master, with an apb register slave and wake outputs.
  assumes the master drives the serial clock and that pin inputs are
  asynchronous to CLK_SYS_IN; serial clock well below a quarter of it.
*/
// Behaviour
// - in slave receive the receiver is never idle while enabled
// - single-receive bit has no effect in synchronous slave mode
// - receive keeps working in sleep when continuous receive was set
// - a complete word moves from the shift register to the data buffer
// - receive interrupt enable lets a received word wake the processor
// - slave mode needs sync mode and port enable, clock master clear
// - nine-bit receive captures ninth bit into status ninth-bit field
// - a received word sets the receive-complete flag and interrupt
// - reading receive data returns the low eight bits of fifo head
// - overrun stays until continuous receive or port enable is cleared
// - clearing port enable resets all serial port logic
// - in sleep only the synchronous slave configuration keeps shifting
// - both shift registers advance only on external serial clock edges
// - reading receive data unloads one character; the flag clears once the fifo is empty
// - receive takes data on data pin and clock on clock pin
// - transmit takes clock on clock pin and drives the data pin
// - after shifting out, buffered byte loads and empty flag sets
// - writing the transmit buffer clears the transmit-empty flag
// - wake with global enable set vectors to the fixed address
// - two queued words: first sends, flag stays clear until second loads
`timescale 1ns/1ps
module sss_top import sss_pkg::*; #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic TRANSMIT_CLOCK_PIN_IN,
  input wire logic RECEIVE_DATA_PIN_IN,
  output logic RECEIVE_DATA_PIN_OUT,
  output logic RECEIVE_DATA_PIN_OE_OUT,
  input wire logic SLEEP_IN,
  output logic WAKE_OUT,
  output logic VECTOR_REQ_OUT,
  output logic [15:0] ISR_VECTOR_OUT
);

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  logic [7:0] rsc_reg;
  logic [7:0] tsc_reg;
  logic [7:0] fe_reg;
  logic [7:0] bc_reg;
  logic [31:0] prdata_reg;
  logic [31:0] read_value;
  logic ck_meta_reg, ck_sync_reg, ck_prev_reg;
  logic dt_meta_reg, dt_sync_reg;
  logic ck_level, ck_prev_level, launch_edge, sample_edge;
  logic port_on, slave_cfg, rx_on, tx_on;
  logic apb_setup, apb_write, apb_read, addr_hit;
  logic [8:0] rx_sr_reg;
  logic [8:0] rx_shifted;
  logic [8:0] rx_word;
  logic [3:0] rx_cnt_reg;
  logic rx_done;
  logic overrun_reg;
  logic [8:0] fifo_mem_reg [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CNT_W-1:0] fifo_cnt_reg;
  logic fifo_full, fifo_push, fifo_pop, rx_flag;
  sss_tx_state_type tx_state_reg;
  logic [8:0] tsr_reg;
  logic [8:0] txbuf_reg;
  logic txbuf_full_reg, tx_nine_reg, tx_load, tx_flag;
  logic [3:0] tx_cnt_reg;
  logic dt_oe_reg, wake_reg, vector_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flip-flops each
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ck_meta_reg <= 1'b0;
      ck_sync_reg <= 1'b0;
      ck_prev_reg <= 1'b0;
      dt_meta_reg <= 1'b0;
      dt_sync_reg <= 1'b0;
    end else begin
      ck_meta_reg <= TRANSMIT_CLOCK_PIN_IN;
      ck_sync_reg <= ck_meta_reg;
      ck_prev_reg <= ck_sync_reg;
      dt_meta_reg <= RECEIVE_DATA_PIN_IN;
      dt_sync_reg <= dt_meta_reg;
    end
  end

  // serial clock edges; the polarity bit picks which edge samples
  always_comb begin
    ck_level = ck_sync_reg ^ bc_reg[SSS_BC_CLOCK_POLARITY];
    ck_prev_level = ck_prev_reg ^ bc_reg[SSS_BC_CLOCK_POLARITY];
    launch_edge = ck_level & ~ck_prev_level;
    sample_edge = ~ck_level & ck_prev_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode; only the slave setup ever shifts, and since
  // it runs off the external clock it carries on through sleep
  always_comb begin
    port_on = rsc_reg[SSS_RSC_PORT_ENABLE];
    slave_cfg = port_on & tsc_reg[SSS_TSC_SYNC_MODE]
      & ~tsc_reg[SSS_TSC_CLOCK_MASTER];
    // sleep state is not consulted
    rx_on = slave_cfg & rsc_reg[SSS_RSC_CONT_RECEIVE];
    tx_on = slave_cfg & ~rsc_reg[SSS_RSC_CONT_RECEIVE]
      & tsc_reg[SSS_TSC_SEND_ENABLE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states
  always_comb begin
    apb_setup = PSEL_IN & ~PENABLE_IN;
    apb_write = PSEL_IN & PENABLE_IN & PWRITE_IN;
    apb_read = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
    addr_hit = (PADDR_IN == SSS_OFS_RX_STATUS_CONTROL)
      | (PADDR_IN == SSS_OFS_TX_STATUS_CONTROL)
      | (PADDR_IN == SSS_OFS_RECEIVE_DATA)
      | (PADDR_IN == SSS_OFS_TRANSMIT_BUFFER)
      | (PADDR_IN == SSS_OFS_FLAGS_ENABLES)
      | (PADDR_IN == SSS_OFS_BAUD_CONTROL);
    PREADY_OUT = 1'b1;
    PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_hit;
  end

  // control registers, writable bits only
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rsc_reg <= SSS_RESET_CONTROL;
      tsc_reg <= SSS_RESET_CONTROL;
      fe_reg <= SSS_RESET_CONTROL;
      bc_reg <= SSS_RESET_CONTROL;
    end else if (apb_write) begin
      if (PADDR_IN == SSS_OFS_RX_STATUS_CONTROL) begin
        rsc_reg <= PWDATA_IN[7:0] & SSS_RSC_WRITE_MASK;
      end
      if (PADDR_IN == SSS_OFS_TX_STATUS_CONTROL) begin
        tsc_reg <= PWDATA_IN[7:0] & SSS_TSC_WRITE_MASK;
      end
      if (PADDR_IN == SSS_OFS_FLAGS_ENABLES) begin
        fe_reg <= PWDATA_IN[7:0] & SSS_FE_WRITE_MASK;
      end
      if (PADDR_IN == SSS_OFS_BAUD_CONTROL) begin
        bc_reg <= PWDATA_IN[7:0] & SSS_BC_WRITE_MASK;
      end
    end
  end

  // read value, captured in the setup phase
  always_comb begin
    read_value = 32'h0000_0000;
    case (PADDR_IN)
      SSS_OFS_RX_STATUS_CONTROL: begin
        read_value[7:0] = rsc_reg;
        read_value[SSS_RSC_OVERRUN_ERROR] = overrun_reg;
        read_value[SSS_RSC_NINTH_BIT] = fifo_mem_reg[rd_ptr_reg][8];
      end
      SSS_OFS_TX_STATUS_CONTROL: begin
        read_value[7:0] = tsc_reg;
        read_value[SSS_TSC_SHIFT_EMPTY] = (tx_state_reg == SSS_TX_IDLE);
      end
      SSS_OFS_RECEIVE_DATA: begin
        read_value[7:0] = fifo_mem_reg[rd_ptr_reg][7:0];
      end
      SSS_OFS_FLAGS_ENABLES: begin
        read_value[7:0] = fe_reg;
        read_value[SSS_FE_RX_COMPLETE] = rx_flag;
        read_value[SSS_FE_TX_EMPTY] = tx_flag;
      end
      SSS_OFS_BAUD_CONTROL: begin
        read_value[7:0] = bc_reg;
        read_value[SSS_BC_RX_IDLE] = ~rx_on;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_reg <= read_value;
    end
  end

  assign PRDATA_OUT = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // receive shift register, sampled on the sample edge
  always_comb begin
    rx_shifted = {dt_sync_reg, rx_sr_reg[8:1]};
    if (rsc_reg[SSS_RSC_NINE_BIT_RECEIVE]) begin
      rx_word = rx_shifted;
    end else begin
      rx_word = {1'b0, rx_shifted[8:1]};
    end
    rx_done = rx_on & sample_edge & ~overrun_reg
      & (rx_cnt_reg == (rsc_reg[SSS_RSC_NINE_BIT_RECEIVE] ?
         SSS_LAST_BIT_9 : SSS_LAST_BIT_8));
    fifo_full = (fifo_cnt_reg == CNT_W'(FIFO_DEPTH));
    fifo_push = rx_done & ~fifo_full;
    fifo_pop = apb_read & (PADDR_IN == SSS_OFS_RECEIVE_DATA)
      & (fifo_cnt_reg != '0);
    rx_flag = (fifo_cnt_reg != '0);
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_sr_reg <= 9'h000;
      rx_cnt_reg <= 4'h0;
      overrun_reg <= 1'b0;
    end else if (!rx_on) begin
      rx_cnt_reg <= 4'h0;
      overrun_reg <= 1'b0;
    end else if (rx_done) begin
      rx_cnt_reg <= 4'h0;
      if (fifo_full) begin
        overrun_reg <= 1'b1;
      end
    end else if (sample_edge && !overrun_reg) begin
      rx_sr_reg <= rx_shifted;
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
    end
  end

  // receive fifo
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fifo_cnt_reg <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem_reg[i] <= 9'h000;
      end
    end else if (!port_on) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fifo_cnt_reg <= '0;
    end else begin
      if (fifo_push) begin
        fifo_mem_reg[wr_ptr_reg] <= rx_word;
        if (wr_ptr_reg == PTR_W'(FIFO_DEPTH - 1)) begin
          wr_ptr_reg <= '0;
        end else begin
          wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
        end
      end
      if (fifo_pop) begin
        if (rd_ptr_reg == PTR_W'(FIFO_DEPTH - 1)) begin
          rd_ptr_reg <= '0;
        end else begin
          rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
        end
      end
      if (fifo_push && !fifo_pop) begin
        fifo_cnt_reg <= fifo_cnt_reg + CNT_W'(1);
      end else if (fifo_pop && !fifo_push) begin
        fifo_cnt_reg <= fifo_cnt_reg - CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer and shift register
  always_comb begin
    tx_load = tx_on & txbuf_full_reg & (tx_state_reg == SSS_TX_IDLE);
    tx_flag = ~txbuf_full_reg;
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      txbuf_reg <= 9'h000;
      txbuf_full_reg <= 1'b0;
    end else if (!port_on) begin
      txbuf_full_reg <= 1'b0;
    end else if (apb_write && PADDR_IN == SSS_OFS_TRANSMIT_BUFFER) begin
      txbuf_reg <= {tsc_reg[SSS_TSC_NINTH_SEND_BIT], PWDATA_IN[7:0]};
      txbuf_full_reg <= 1'b1;
    end else if (tx_load) begin
      txbuf_full_reg <= 1'b0;
    end
  end

  // bit 0 goes out at load; later bits change on launch edges
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_state_reg <= SSS_TX_IDLE;
      tsr_reg <= 9'h000;
      tx_cnt_reg <= 4'h0;
      tx_nine_reg <= 1'b0;
    end else if (!tx_on) begin
      tx_state_reg <= SSS_TX_IDLE;
      tx_cnt_reg <= 4'h0;
    end else begin
      case (tx_state_reg)
        SSS_TX_IDLE: begin
          if (tx_load) begin
            tsr_reg <= txbuf_reg;
            tx_nine_reg <= tsc_reg[SSS_TSC_NINE_BIT_SEND];
            tx_cnt_reg <= 4'h0;
            tx_state_reg <= SSS_TX_SHIFT;
          end
        end
        SSS_TX_SHIFT: begin
          if (sample_edge) begin
            if (tx_cnt_reg == (tx_nine_reg ? SSS_LAST_BIT_9 :
                SSS_LAST_BIT_8)) begin
              tx_state_reg <= SSS_TX_IDLE;
            end
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
          end else if (launch_edge && tx_cnt_reg != 4'h0) begin
            tsr_reg <= {1'b0, tsr_reg[8:1]};
          end
        end
        default: begin
          tx_state_reg <= SSS_TX_IDLE;
        end
      endcase
    end
  end

  // data pin drive, enabled for the whole transmit configuration
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dt_oe_reg <= 1'b0;
    end else begin
      dt_oe_reg <= tx_on;
    end
  end

  assign RECEIVE_DATA_PIN_OUT = tsr_reg[0];
  assign RECEIVE_DATA_PIN_OE_OUT = dt_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // wake and vector requests toward the processor core
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wake_reg <= 1'b0;
      vector_reg <= 1'b0;
    end else begin
      wake_reg <= (rx_flag & fe_reg[SSS_FE_RX_INT_EN])
        | (tx_flag & fe_reg[SSS_FE_TX_INT_EN]
           & fe_reg[SSS_FE_PERIPH_INT_EN]);
      vector_reg <= fe_reg[SSS_FE_GLOBAL_INT_EN] & ((rx_flag
        & fe_reg[SSS_FE_RX_INT_EN]) | (tx_flag & fe_reg[SSS_FE_TX_INT_EN]
        & fe_reg[SSS_FE_PERIPH_INT_EN]));
    end
  end

  assign WAKE_OUT = wake_reg;
  assign VECTOR_REQ_OUT = vector_reg;
  assign ISR_VECTOR_OUT = SSS_ISR_VECTOR;

endmodule // sss_top

// [verif/sss_chk.sv]
/*
  port checker of the synchronous serial slave, bound to sss_top.
  assumes one clock domain with an active high asynchronous reset.
*/
`timescale 1ns/1ps
module sss_chk import sss_pkg::*; #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic TRANSMIT_CLOCK_PIN_IN,
  input wire logic RECEIVE_DATA_PIN_OUT,
  input wire logic RECEIVE_DATA_PIN_OE_OUT,
  input wire logic SLEEP_IN,
  input wire logic WAKE_OUT,
  input wire logic VECTOR_REQ_OUT,
  input wire logic [15:0] ISR_VECTOR_OUT
);
  logic [7:0] acc_cnt;
  logic [7:0] edge_cnt;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  //////////////////////////////////////////////////////////////////////////
  // cycles since the last apb access phase, saturating
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) acc_cnt <= 8'h00;
    else if (PSEL_IN && PENABLE_IN) acc_cnt <= 8'h00;
    else if (acc_cnt != 8'hff) acc_cnt <= acc_cnt + 8'h01;
  end

  // cycles since the serial clock pin last moved, saturating
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) edge_cnt <= 8'h00;
    else if ($changed(TRANSMIT_CLOCK_PIN_IN)) edge_cnt <= 8'h00;
    else if (edge_cnt != 8'hff) edge_cnt <= edge_cnt + 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  // properties
  property p_vector_addr;
    $rose(VECTOR_REQ_OUT) |-> WAKE_OUT && ISR_VECTOR_OUT == SSS_ISR_VECTOR;
  endproperty
  a_vector_addr: assert property (p_vector_addr)
    else $error("vector request without wake or wrong address");
  property p_vector_gate;
    VECTOR_REQ_OUT |-> WAKE_OUT;
  endproperty
  a_vector_gate: assert property (p_vector_gate)
    else $error("vector request while wake is low");
  property p_rd_low_byte;
    PSEL_IN && PENABLE_IN && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h000000;
  endproperty
  a_rd_low_byte: assert property (p_rd_low_byte)
    else $error("read data upper bits not zero");
  property p_wake_fall;
    $fell(WAKE_OUT) |-> acc_cnt <= 8'h03;
  endproperty
  a_wake_fall: assert property (p_wake_fall)
    else $error("wake fell without a register access");
  property p_wake_rise;
    $rose(WAKE_OUT) && acc_cnt > 8'h04 |-> edge_cnt <= 8'h0a;
  endproperty
  a_wake_rise: assert property (p_wake_rise)
    else $error("wake rose without a serial clock edge");
  property p_pin_stable;
    $changed(RECEIVE_DATA_PIN_OUT) |-> acc_cnt <= 8'h04 || edge_cnt <= 8'h08;
  endproperty
  a_pin_stable: assert property (p_pin_stable)
    else $error("data pin moved without a serial clock edge");
  property p_oe_config;
    $changed(RECEIVE_DATA_PIN_OE_OUT) |-> acc_cnt <= 8'h03;
  endproperty
  a_oe_config: assert property (p_oe_config)
    else $error("data pin enable moved without a register write");
  property p_sleep_ignored;
    $rose(SLEEP_IN) && acc_cnt > 8'h08 && edge_cnt > 8'h0c |=>
      $stable(WAKE_OUT) ##1 $stable(WAKE_OUT);
  endproperty
  a_sleep_ignored: assert property (p_sleep_ignored)
    else $error("wake moved on entry to sleep");

  // main scenarios reached
  c_wake: cover property ($rose(WAKE_OUT));
  c_vector: cover property ($rose(VECTOR_REQ_OUT));
  c_drive: cover property ($rose(RECEIVE_DATA_PIN_OE_OUT));
endmodule // sss_chk

bind sss_top sss_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT),
  .TRANSMIT_CLOCK_PIN_IN(TRANSMIT_CLOCK_PIN_IN),
  .RECEIVE_DATA_PIN_OUT(RECEIVE_DATA_PIN_OUT),
  .RECEIVE_DATA_PIN_OE_OUT(RECEIVE_DATA_PIN_OE_OUT), .SLEEP_IN(SLEEP_IN),
  .WAKE_OUT(WAKE_OUT), .VECTOR_REQ_OUT(VECTOR_REQ_OUT),
  .ISR_VECTOR_OUT(ISR_VECTOR_OUT));

// [verif/sss_master_model.sv]
/*
  external synchronous master: makes the serial clock and data.
  assumes 160 ns clock period, clock low outside frames.
*/
`timescale 1ns/1ps
module sss_master_model (
  output logic sck_out,
  output logic data_out,
  input wire logic data_in
);
  // idle levels
  initial begin
    sck_out = 1'b0;
    data_out = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // one word, lsb first; samples the line mid low phase after each fall
  task automatic xfer(input logic [8:0] w, input int n,
                      output logic [8:0] q);
    q = 9'h000;
    #5; // keep pin moves clear of the system clock edges
    for (int i = 0; i < n; i++) begin
      data_out = w[i];
      #40;
      sck_out = 1'b1;
      #80;
      sck_out = 1'b0;
      #40;
      q[i] = data_in;
    end
    #40;
    data_out = ~w[n-1]; // released line shows the inverse
  endtask
endmodule // sss_master_model

// [verif/sync_serial_slave_sleep_test.sv]
/*
  testbench of the synchronous serial slave with an external master.
  assumes apb answers in its own time and a 50 MHz system clock.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  fail_count++; $display("Error at %0t: got %0h expected %0h", $time, \
  (got), (exp)); end end
module sync_serial_slave_sleep_test import sss_pkg::*;;
  logic clk, rst, psel, pen, pwr, sleep;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [15:0] vec;
  logic [8:0] q;
  logic pready, pslverr, dout, doe, wake, vreq, sck, mdrv;
  wire dat;
  int fail_count = 0;
  int tests_run = 0;

  // device, master and resolved data line
  sss_top u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TRANSMIT_CLOCK_PIN_IN(sck),
    .RECEIVE_DATA_PIN_IN(dat), .RECEIVE_DATA_PIN_OUT(dout),
    .RECEIVE_DATA_PIN_OE_OUT(doe), .SLEEP_IN(sleep), .WAKE_OUT(wake),
    .VECTOR_REQ_OUT(vreq), .ISR_VECTOR_OUT(vec));
  sss_master_model u_mst (.sck_out(sck), .data_out(mdrv), .data_in(dat));
  assign dat = doe ? dout : mdrv;

  //////////////////////////////////////////////////////////////////////////
  // clock and run end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("tests %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////////
  // apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] m,
                        input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    `CHK(r[7:0] & m, x)
  endtask
  task automatic wait_wake(input logic x);
    int n;
    n = 0;
    @(posedge clk);
    while (wake !== x && n < 80) begin
      @(posedge clk);
      n++;
    end
    `CHK(wake, x)
  endtask

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd_chk(SSS_OFS_RX_STATUS_CONTROL, 8'hff, 8'h00);
    rd_chk(SSS_OFS_FLAGS_ENABLES, 8'hff, 8'h02);
    apb(1'b0, 12'h020, 8'h00, r, e);
    `CHK(e, 1'b1)
    `CHK(r, 32'h00000000)
  endtask
  task automatic t_rx();
    wr(SSS_OFS_TX_STATUS_CONTROL, 8'h10);
    wr(SSS_OFS_RX_STATUS_CONTROL, 8'hb0);
    wr(SSS_OFS_FLAGS_ENABLES, 8'h90);
    rd_chk(SSS_OFS_BAUD_CONTROL, 8'h40, 8'h00);
    repeat (20) @(posedge clk);
    sleep <= 1'b1;
    u_mst.xfer(9'h0a5, 8, q);
    wait_wake(1'b1);
    `CHK(vreq, 1'b1)
    `CHK(vec, SSS_ISR_VECTOR)
    rd_chk(SSS_OFS_FLAGS_ENABLES, 8'h01, 8'h01);
    rd_chk(SSS_OFS_RECEIVE_DATA, 8'hff, 8'ha5);
    wait_wake(1'b0);
    sleep <= 1'b0;
  endtask
  task automatic t_rx9();
    wr(SSS_OFS_RX_STATUS_CONTROL, 8'hd0);
    // inverted clock polarity: the rising pin edge samples this word
    wr(SSS_OFS_BAUD_CONTROL, 8'h10);
    rd_chk(SSS_OFS_BAUD_CONTROL, 8'h50, 8'h10);
    u_mst.xfer(9'h13c, 9, q);
    wait_wake(1'b1);
    rd_chk(SSS_OFS_RX_STATUS_CONTROL, 8'h01, 8'h01);
    rd_chk(SSS_OFS_RECEIVE_DATA, 8'hff, 8'h3c);
    wr(SSS_OFS_BAUD_CONTROL, 8'h00);
  endtask
  task automatic t_overrun();
    wr(SSS_OFS_RX_STATUS_CONTROL, 8'h90);
    u_mst.xfer(9'h011, 8, q);
    u_mst.xfer(9'h022, 8, q);
    u_mst.xfer(9'h033, 8, q);
    repeat (10) @(posedge clk);
    rd_chk(SSS_OFS_RX_STATUS_CONTROL, 8'h02, 8'h02);
    wr(SSS_OFS_RX_STATUS_CONTROL, 8'h80);
    rd_chk(SSS_OFS_RX_STATUS_CONTROL, 8'h02, 8'h00);
    rd_chk(SSS_OFS_RECEIVE_DATA, 8'hff, 8'h11);
    wr(SSS_OFS_RX_STATUS_CONTROL, 8'h00);
    rd_chk(SSS_OFS_FLAGS_ENABLES, 8'h01, 8'h00);
  endtask
  task automatic t_tx();
    wr(SSS_OFS_TX_STATUS_CONTROL, 8'h30);
    wr(SSS_OFS_RX_STATUS_CONTROL, 8'h80);
    wr(SSS_OFS_FLAGS_ENABLES, 8'h60);
    wr(SSS_OFS_TRANSMIT_BUFFER, 8'h5a);
    // second word goes out as nine bits with the ninth bit set
    wr(SSS_OFS_TX_STATUS_CONTROL, 8'h71);
    wr(SSS_OFS_TRANSMIT_BUFFER, 8'hc3);
    rd_chk(SSS_OFS_FLAGS_ENABLES, 8'h02, 8'h00);
    `CHK(wake, 1'b0)
    `CHK(doe, 1'b1)
    u_mst.xfer(9'h000, 8, q);
    `CHK(q[7:0], 8'h5a)
    wait_wake(1'b1);
    rd_chk(SSS_OFS_FLAGS_ENABLES, 8'h02, 8'h02);
    u_mst.xfer(9'h000, 9, q);
    `CHK(q, 9'h1c3)
    @(posedge clk);
    rd_chk(SSS_OFS_TX_STATUS_CONTROL, 8'h02, 8'h02);
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    sleep = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rx();
    t_rx9();
    t_overrun();
    t_tx();
    report_and_stop();
  end
endmodule // sync_serial_slave_sleep_test
